// File: src/acs_pkg.sv
package acs_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ACS_PRESC_W = 7;
    localparam int ACS_CYC_W = 5;
    localparam int ACS_RESULT_W = 10;
    localparam int ACS_CHAN_W = 2;
    localparam int ACS_REF_W = 1;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    localparam logic [7:0] ACS_DIV_ONE = 8'h01;
    localparam logic [7:0] ACS_DIV_MIN = 8'h02;
    localparam logic [2:0] ACS_DIV_SEL_ZERO = 3'h0;
    localparam logic [ACS_PRESC_W-1:0] ACS_PRESC_RESET = 7'h00;

    // ------------------------------------------------------------
    // Conversion timing, in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [ACS_CYC_W-1:0] ACS_LEN_NORMAL = 5'h0d;
    localparam logic [ACS_CYC_W-1:0] ACS_LEN_FIRST = 5'h19;
    // Sample-and-hold: on the falling half of this cycle index (x.5)
    localparam logic [ACS_CYC_W-1:0] ACS_SH_NORMAL = 5'h01;
    localparam logic [ACS_CYC_W-1:0] ACS_SH_FIRST = 5'h0e;
    // Auto trigger: on the rising edge that ends this cycle index
    localparam logic [ACS_CYC_W-1:0] ACS_SH_AUTO = 5'h01;
    localparam logic [ACS_CYC_W-1:0] ACS_CYC_ONE = 5'h01;
    localparam logic [ACS_CYC_W-1:0] ACS_CYC_RESET = 5'h00;

    // ------------------------------------------------------------
    // Sleep modes seen by the sequencer
    // ------------------------------------------------------------
    localparam logic [1:0] ACS_SLEEP_IDLE = 2'h0;
    localparam logic [1:0] ACS_SLEEP_NOISE = 2'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ACS_RESULT_W-1:0] ACS_RESULT_RESET = 10'h000;
    localparam logic [ACS_CHAN_W-1:0] ACS_CHAN_RESET = 2'h0;
    localparam logic [ACS_REF_W-1:0] ACS_REF_RESET = 1'h0;

    typedef enum logic {ACS_IDLE, ACS_CONVERT} acs_state_t;

endpackage

// File: src/acs_prescaler.sv
`timescale 1ns/1ps
module acs_prescaler
    import acs_pkg::*;
#(
    parameter int CNT_W = ACS_PRESC_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] div_sel,
    output logic rise_tick,
    output logic fall_tick
);

    // ------------------------------------------------------------
    // Division factor decode
    // ------------------------------------------------------------
    // Code 0 divides by 2 as code 1 does
    wire [7:0] div_w = (div_sel == ACS_DIV_SEL_ZERO) ? ACS_DIV_MIN : (ACS_DIV_ONE << div_sel); // [R23]
    wire [7:0] term_w = div_w - ACS_DIV_ONE;
    wire [7:0] half_w = (div_w >> 1) - ACS_DIV_ONE;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire at_term = (cnt_reg == term_w[CNT_W-1:0]);
    wire at_half = (cnt_reg == half_w[CNT_W-1:0]);

    // Ticks are enables in the cpu domain, no derived clock net
    assign rise_tick = clk_en & run & ~restart & at_term; // [R26]
    assign fall_tick = clk_en & run & ~restart & at_half;

    // Held at zero while disabled, zeroed on a trigger restart
    assign cnt_next = (!run || restart || at_term) ? ACS_PRESC_RESET : cnt_reg + 1'b1; // [R01] [R09]

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= ACS_PRESC_RESET;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// File: src/acs_sequencer.sv
`timescale 1ns/1ps
// Contract
// R01 - Prescaler runs while enabled, held otherwise
// R02 - Software keeps converter clock 50-200 kHz
// R03 - Start waits for next converter clock edge
// R04 - Normal conversion lasts 13 clock cycles
// R05 - First conversion after enable lasts 25
// R06 - Normal sample-and-hold at 1.5 cycles
// R07 - First sample-and-hold at 14.5 cycles
// R08 - Completion stores result, sets flag, clears start
// R09 - Trigger restarts prescaler; sample after two cycles
// R10 - Trigger synchronisation adds three cpu cycles
// R11 - Free running restarts at once, start stays
// R12 - Selection tracks temp while idle, locks
// R13 - Selection tracks again in last cycle
// R14 - Software waits a cycle before new selection
// R15 - Auto trigger: change selection at safe points
// R16 - Safe-point change applies to next conversion
// R17 - Free running: running conversion keeps old channel
// R18 - Software discards first result after reference change
// R19 - Sleep start needs enabled, idle, single, irq on
// R20 - Qualifying sleep starts conversion when cpu halts
// R21 - Completion irq raised even after early wake
// R22 - Other sleep modes leave enable untouched
// R23 - Divider codes give 2,2,4,...,128
// R24 - Trigger edges during conversion are ignored
// R25 - Flag clears by write-one or vector
// R26 - Converter clock is a tick enable
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int RESULT_W = ACS_RESULT_W,
    parameter int CHAN_W = ACS_CHAN_W,
    parameter int REF_W = ACS_REF_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic converter_enable,
    input wire logic [2:0] clock_divider_select,
    input wire logic auto_trigger_enable,
    input wire logic free_run_select,
    input wire logic irq_enable,
    input wire logic start_conversion_wr,
    input wire logic done_flag_clear_wr,
    input wire logic irq_vector_ack,
    input wire logic select_wr,
    input wire logic [CHAN_W-1:0] channel_select_wdata,
    input wire logic [REF_W-1:0] reference_select_wdata,
    input wire logic trigger_in,
    input wire logic cpu_halted,
    input wire logic [1:0] sleep_mode,
    input wire logic [RESULT_W-1:0] analog_result,
    output logic start_conversion,
    output logic conversion_done_flag,
    output logic irq_request,
    output logic [RESULT_W-1:0] result_data,
    output logic [CHAN_W-1:0] channel_select_temp,
    output logic [REF_W-1:0] reference_select_temp,
    output logic [CHAN_W-1:0] channel_select,
    output logic [REF_W-1:0] reference_select,
    output logic sample_hold,
    output logic conversion_busy,
    output logic converter_tick
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    acs_state_t state_reg;
    logic [ACS_CYC_W-1:0] cyc_reg;
    logic start_reg;
    logic done_reg;
    logic first_pend_reg;
    logic conv_first_reg;
    logic conv_auto_reg;
    logic halted_last_reg;
    logic sh_reg;
    logic [RESULT_W-1:0] result_reg;
    logic [CHAN_W-1:0] chan_temp_reg;
    logic [REF_W-1:0] ref_temp_reg;
    logic [CHAN_W-1:0] chan_work_reg;
    logic [REF_W-1:0] ref_work_reg;
    logic rise_tick;
    logic fall_tick;
    logic trig_edge;
    logic auto_go;

    // ------------------------------------------------------------
    // Clock tick and trigger synchroniser
    // ------------------------------------------------------------
    acs_prescaler #(
        .CNT_W(ACS_PRESC_W)
    ) u_prescaler (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(converter_enable),
        .restart(auto_go),
        .div_sel(clock_divider_select),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick)
    );

    acs_trigger_sync u_trigger_sync (
        .clk(clk),
        .clk_en(clk_en),
        .reset(reset),
        .trigger_in(trigger_in),
        .trigger_edge(trig_edge)
    );

    // ------------------------------------------------------------
    // Start and completion decode
    // ------------------------------------------------------------
    wire idle = (state_reg == ACS_IDLE);
    wire busy = (state_reg == ACS_CONVERT);
    wire free_run = auto_trigger_enable & free_run_select;
    // Triggers are only seen while idle, so a second edge mid-conversion is dropped
    assign auto_go = idle & converter_enable & auto_trigger_enable & ~free_run_select & trig_edge; // [R09] [R24]
    wire manual_go = idle & converter_enable & start_reg & rise_tick; // [R03]
    wire go = manual_go | auto_go;
    wire [ACS_CYC_W-1:0] conv_len = conv_first_reg ? ACS_LEN_FIRST : ACS_LEN_NORMAL; // [R04] [R05]
    wire last_cycle = busy & (cyc_reg == conv_len - ACS_CYC_ONE);
    wire complete = last_cycle & rise_tick;
    wire halt_edge = clk_en & cpu_halted & ~halted_last_reg;
    // Only idle and noise sleep start a conversion; enable is never touched here
    wire sleep_mode_ok = (sleep_mode == ACS_SLEEP_IDLE) | (sleep_mode == ACS_SLEEP_NOISE); // [R22]
    wire sleep_go = halt_edge & sleep_mode_ok & converter_enable & idle & ~start_reg
        & ~auto_trigger_enable & irq_enable; // [R20]
    wire sh_normal = fall_tick & (cyc_reg == ACS_SH_NORMAL) & ~conv_first_reg & ~conv_auto_reg; // [R06]
    wire sh_first = fall_tick & (cyc_reg == ACS_SH_FIRST) & conv_first_reg & ~conv_auto_reg; // [R07]
    wire sh_auto = rise_tick & (cyc_reg == ACS_SH_AUTO) & conv_auto_reg; // [R09]
    wire sh_now = busy & (sh_normal | sh_first | sh_auto);
    wire track_sel = idle | last_cycle; // [R12] [R13]

    // ------------------------------------------------------------
    // Sequencer state and cycle count
    // ------------------------------------------------------------
    // Disabling the converter aborts any conversion in flight
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ACS_IDLE;
            cyc_reg <= ACS_CYC_RESET;
        end else if (clk_en) begin
            if (!converter_enable) begin
                state_reg <= ACS_IDLE;
                cyc_reg <= ACS_CYC_RESET;
            end else if (go || (complete && free_run)) begin
                state_reg <= ACS_CONVERT; // [R11]
                cyc_reg <= ACS_CYC_RESET;
            end else if (complete) begin
                state_reg <= ACS_IDLE;
                cyc_reg <= ACS_CYC_RESET;
            end else if (busy && rise_tick) begin
                cyc_reg <= cyc_reg + ACS_CYC_ONE; // [R04] [R05]
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion kind: first-after-enable and auto-triggered
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            first_pend_reg <= 1'b1;
            conv_first_reg <= 1'b0;
            conv_auto_reg <= 1'b0;
        end else if (clk_en) begin
            if (!converter_enable) begin
                first_pend_reg <= 1'b1; // [R05]
            end else if (go) begin
                first_pend_reg <= 1'b0;
                conv_first_reg <= first_pend_reg;
                conv_auto_reg <= auto_go;
            end else if (complete) begin
                conv_first_reg <= 1'b0;
                conv_auto_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Start-conversion bit
    // ------------------------------------------------------------
    // A software write in the completion cycle wins over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_reg <= 1'b0;
        end else if (clk_en) begin
            if (!converter_enable) begin
                start_reg <= 1'b0;
            end else if (start_conversion_wr || auto_go || sleep_go) begin
                start_reg <= 1'b1; // [R20]
            end else if (complete && !free_run) begin
                start_reg <= 1'b0; // [R08]
            end
        end
    end

    // ------------------------------------------------------------
    // Completion flag, result, sample strobe
    // ------------------------------------------------------------
    // Set wins over a clear in the same cycle so no completion is lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_reg <= 1'b0;
            result_reg <= ACS_RESULT_RESET;
            sh_reg <= 1'b0;
            halted_last_reg <= 1'b0;
        end else if (clk_en) begin
            halted_last_reg <= cpu_halted;
            sh_reg <= sh_now;
            if (complete) begin
                done_reg <= 1'b1; // [R08]
                result_reg <= analog_result;
            end else if (done_flag_clear_wr || irq_vector_ack) begin
                done_reg <= 1'b0; // [R25]
            end
        end
    end

    // ------------------------------------------------------------
    // Channel and reference selection
    // ------------------------------------------------------------
    // Working copy follows the temporary one only while idle or in the last cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chan_temp_reg <= ACS_CHAN_RESET;
            ref_temp_reg <= ACS_REF_RESET;
            chan_work_reg <= ACS_CHAN_RESET;
            ref_work_reg <= ACS_REF_RESET;
        end else if (clk_en) begin
            if (select_wr) begin
                chan_temp_reg <= channel_select_wdata;
                ref_temp_reg <= reference_select_wdata;
            end
            if (track_sel) begin
                chan_work_reg <= chan_temp_reg; // [R12] [R16] [R17]
                ref_work_reg <= ref_temp_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign start_conversion = start_reg;
    assign conversion_done_flag = done_reg;
    // Request follows the flag, whatever the cpu did meanwhile
    assign irq_request = done_reg & irq_enable; // [R21]
    assign result_data = result_reg;
    assign channel_select_temp = chan_temp_reg;
    assign reference_select_temp = ref_temp_reg;
    assign channel_select = chan_work_reg;
    assign reference_select = ref_work_reg;
    assign sample_hold = sh_reg;
    assign conversion_busy = busy;
    assign converter_tick = rise_tick;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    presc_held_a: assert property (!converter_enable |-> !rise_tick && !fall_tick) // [R01]
        else $error("converter tick while disabled");
    start_tick_a: assert property ($rose(busy) |-> $past(rise_tick) || $past(auto_go)) // [R03]
        else $error("conversion began off a tick");
    len_normal_a: assert property (complete && !conv_first_reg |-> cyc_reg == 5'h0c) // [R04]
        else $error("normal conversion length wrong");
    len_first_a: assert property (complete && conv_first_reg |-> cyc_reg == 5'h18) // [R05]
        else $error("first conversion length wrong");
    sh_normal_a: assert property (sh_now && !conv_first_reg && !conv_auto_reg |-> fall_tick && cyc_reg == 5'h01) // [R06]
        else $error("normal sample strobe misplaced");
    sh_first_a: assert property (sh_now && conv_first_reg && !conv_auto_reg |-> fall_tick && cyc_reg == 5'h0e) // [R07]
        else $error("first sample strobe misplaced");
    done_set_a: assert property (complete && converter_enable |=> done_reg && result_reg == $past(analog_result)) // [R08]
        else $error("completion did not set flag and result");
    single_clr_a: assert property (complete && converter_enable && !free_run && !start_conversion_wr |=> !start_reg) // [R08]
        else $error("start bit not cleared in single mode");
    free_run_a: assert property (complete && converter_enable && free_run |=> busy && start_reg && cyc_reg == 5'h00) // [R11]
        else $error("free running did not restart");
    sel_lock_a: assert property (busy && !last_cycle && clk_en |=> $stable(chan_work_reg) && $stable(ref_work_reg)) // [R12]
        else $error("selection moved while locked");
    trig_ignore_a: assert property (busy && trig_edge |-> !auto_go) // [R24]
        else $error("trigger accepted mid conversion");
    trig_restart_a: assert property (auto_go |=> busy && !rise_tick) // [R09]
        else $error("trigger did not restart prescaler");
    sel_track_a: assert property (last_cycle && clk_en |=> chan_work_reg == $past(chan_temp_reg)) // [R13]
        else $error("selection not tracking in last cycle");
    flag_clear_a: assert property (done_reg && !complete && clk_en && irq_vector_ack |=> !done_reg) // [R25]
        else $error("flag not cleared by vector");

    cov_first_c: cover property (complete && conv_first_reg);
    cov_auto_c: cover property (sh_auto && busy);
    cov_free_c: cover property (complete && free_run);
    cov_sleep_c: cover property (sleep_go);

endmodule

// File: src/acs_trigger_sync.sv
`timescale 1ns/1ps
module acs_trigger_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic trigger_in,
    output logic trigger_edge
);

    // ------------------------------------------------------------
    // Two-stage synchroniser plus edge register
    // ------------------------------------------------------------
    // Two cpu cycles from pin to edge pulse, three to conversion start; the first stage feeds only the second
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= trigger_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Rising edge only, one cycle wide
    assign trigger_edge = clk_en & sync_reg & ~last_reg; // [R10]

endmodule

// File: verification/acs_analog_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog sample-and-hold and comparison core, behavioural
// ------------------------------------------------------------
module acs_analog_model
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_hold,
    input wire logic [ACS_CHAN_W-1:0] channel_select,
    input wire logic [ACS_REF_W-1:0] reference_select,
    output logic [ACS_RESULT_W-1:0] analog_result
);
    logic [ACS_RESULT_W-1:0] held_reg;
    logic held_valid_reg;
    logic [ACS_RESULT_W-1:0] noise_reg;

    // Code depends on the selection seen at the strobe, so a late mux change shows up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            held_reg <= 10'h000;
            held_valid_reg <= 1'b0;
        end else if (sample_hold) begin
            held_reg <= {reference_select, 7'h2a, channel_select};
            held_valid_reg <= 1'b1;
        end
    end

    // Before any sample the output is junk that changes every cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            noise_reg <= 10'h155;
        end else begin
            noise_reg <= ~noise_reg;
        end
    end

    assign analog_result = held_valid_reg ? held_reg : noise_reg;
endmodule

// File: verification/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
    logic clk, reset, clk_en, en, auto, free, irq_en, st_wr, clr_wr, ack, sel_wr, trig, halted, rf_wd;
    logic [2:0] dsel;
    logic [1:0] ch_wd, smode;
    logic [9:0] ares, result_data;
    logic start_conversion, conversion_done_flag, irq_request, sample_hold, conversion_busy, converter_tick;
    logic [1:0] channel_select_temp, channel_select;
    logic reference_select_temp, reference_select;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, k, g;
    int divs[8] = '{2, 2, 4, 8, 16, 32, 64, 128};

    acs_sequencer u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .converter_enable(en),
        .clock_divider_select(dsel), .auto_trigger_enable(auto), .free_run_select(free),
        .irq_enable(irq_en), .start_conversion_wr(st_wr), .done_flag_clear_wr(clr_wr),
        .irq_vector_ack(ack), .select_wr(sel_wr), .channel_select_wdata(ch_wd),
        .reference_select_wdata(rf_wd), .trigger_in(trig), .cpu_halted(halted), .sleep_mode(smode),
        .analog_result(ares), .start_conversion(start_conversion),
        .conversion_done_flag(conversion_done_flag), .irq_request(irq_request),
        .result_data(result_data), .channel_select_temp(channel_select_temp),
        .reference_select_temp(reference_select_temp), .channel_select(channel_select),
        .reference_select(reference_select), .sample_hold(sample_hold),
        .conversion_busy(conversion_busy), .converter_tick(converter_tick));

    acs_analog_model u_core (.clk(clk), .reset(reset), .sample_hold(sample_hold),
        .channel_select(channel_select), .reference_select(reference_select), .analog_result(ares));

    // ------------------------------------------------------------
    // Clock, hang guard, reporting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic print_verdict;
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("Error at %0t: run did not finish", $time);
            print_verdict;
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: value %0h, expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_res(input logic [1:0] ch, input logic rf);
        return {6'h00, rf, 7'h2a, ch};
    endfunction

    // ------------------------------------------------------------
    // Software access, all launched on the falling edge
    // ------------------------------------------------------------
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic sel(input logic [1:0] c, input logic r);
        ch_wd = c;
        rf_wd = r;
        pulse(sel_wr);
    endtask

    task automatic wait_flag;
        int t;
        t = 0;
        while (conversion_done_flag !== 1'b1 && t < 3000) begin
            @(negedge clk);
            t++;
        end
        chk_val(16'(conversion_done_flag), 16'h0001);
    endtask

    // Cycles between two converter ticks, taken on the second interval
    task automatic gap(output int c);
        c = 0;
        while (converter_tick !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        @(negedge clk);
        c = 1;
        while (converter_tick !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
        end
    endtask

    // Ticks while busy, and ticks already seen when the strobe comes
    task automatic measure(input int len_e, input int sh_e);
        int cnt, sh, t;
        cnt = 0;
        sh = -1;
        t = 0;
        while (conversion_busy !== 1'b1 && t < 4000) begin
            @(negedge clk);
            t++;
        end
        while (conversion_busy === 1'b1 && t < 8000) begin
            if (sample_hold === 1'b1) sh = cnt;
            if (converter_tick === 1'b1) cnt++;
            @(negedge clk);
            t++;
        end
        chk_count(cnt, len_e);
        chk_count(sh, sh_e);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {en, auto, free, irq_en, st_wr, clr_wr, ack, sel_wr, trig, halted, rf_wd} = 11'h000;
        {dsel, ch_wd, smode} = 7'h00;
        clk_en = 1'b1;
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        chk_val(16'({start_conversion, conversion_done_flag, conversion_busy}), 16'h0000);
        // Disabled: prescaler frozen and start writes refused
        n = 0;
        pulse(st_wr);
        repeat (20) begin
            @(negedge clk);
            if (converter_tick === 1'b1) n++;
        end
        chk_count(n, 0);
        chk_val(16'(start_conversion), 16'h0000);
        // Every divider code
        en = 1'b1;
        for (k = 0; k < 8; k++) begin
            dsel = 3'(k);
            gap(g);
            gap(g);
            chk_count(g, divs[k]);
        end
        clk_en = 1'b0;
        n = 0;
        repeat (200) begin
            @(negedge clk);
            if (converter_tick === 1'b1) n++;
        end
        chk_count(n, 0);
        clk_en = 1'b1;
        en = 1'b0;
        dsel = 3'h0;
        idle(2);
        // First conversion after enable; divider code 0 runs the converter clock at half the cpu clock
        sel(2'h1, 1'b0);
        irq_en = 1'b1;
        en = 1'b1;
        pulse(st_wr);
        measure(25, 14);
        chk_val(16'({conversion_done_flag, start_conversion, irq_request}), 16'h0005);
        chk_val(16'(result_data), exp_res(2'h1, 1'b0));
        pulse(clr_wr);
        chk_val(16'({conversion_done_flag, irq_request}), 16'h0000);
        // Selection written mid-conversion stays out of the running one
        pulse(st_wr);
        fork
            measure(13, 1);
            begin
                idle(8);
                sel(2'h2, 1'b1);
                chk_val(16'(channel_select_temp), 16'h0002);
                chk_val(16'({channel_select, reference_select}), 16'h0002);
            end
        join
        chk_val(16'(result_data), exp_res(2'h1, 1'b0));
        chk_val(16'({channel_select, reference_select}), 16'h0005);
        pulse(ack);
        chk_val(16'(conversion_done_flag), 16'h0000);
        // Reference just switched: software would drop this result
        pulse(st_wr);
        measure(13, 1);
        chk_val(16'(result_data), exp_res(2'h2, 1'b1));
        pulse(clr_wr);
        // Free running: channel change after a completion lands one later
        auto = 1'b1;
        free = 1'b1;
        pulse(st_wr);
        wait_flag;
        sel(2'h3, 1'b1);
        pulse(clr_wr);
        wait_flag;
        chk_val(16'(result_data), exp_res(2'h2, 1'b1));
        chk_val(16'(start_conversion), 16'h0001);
        pulse(clr_wr);
        wait_flag;
        chk_val(16'(result_data), exp_res(2'h3, 1'b1));
        free = 1'b0;
        auto = 1'b0;
        idle(60);
        pulse(clr_wr);
        // Auto trigger with a second edge during the conversion
        auto = 1'b1;
        fork
            measure(13, 2);
            begin
                trig = 1'b1;
                n = 0;
                while (conversion_busy !== 1'b1 && n < 20) begin
                    @(negedge clk);
                    n++;
                end
                chk_val(16'(n >= 3 && n <= 5), 16'h0001);
                idle(4);
                trig = 1'b0;
                idle(2);
                trig = 1'b1;
            end
        join
        idle(40);
        chk_val(16'(conversion_busy), 16'h0000);
        trig = 1'b0;
        auto = 1'b0;
        pulse(clr_wr);
        // Other sleep modes leave the converter alone
        smode = 2'h2;
        halted = 1'b1;
        idle(20);
        chk_val(16'({start_conversion, conversion_busy}), 16'h0000);
        halted = 1'b0;
        idle(2);
        // Noise reduction sleep, woken early by something else
        smode = 2'h1;
        halted = 1'b1;
        fork
            measure(13, 1);
            begin
                idle(10);
                halted = 1'b0;
            end
        join
        chk_val(16'({conversion_done_flag, irq_request}), 16'h0003);
        pulse(ack);
        print_verdict;
    end
endmodule
